// ===== lbc_pkg.sv
// shared types and constants for the local bus control block
// assumes one system clock; chip-select ranges arrive as a loaded config word
package lbc_pkg;

  localparam logic [19:0] UPPER_RESET_START  = 20'hFFC00;
  localparam logic [19:0] UPPER_RESET_END    = 20'hFFFFF;
  localparam logic [19:0] ADDR_ZERO          = 20'h00000;
  localparam logic [3:0]  MID_SHIFT_RESET    = 4'h0;
  localparam int          PERIPH_BLOCK_SHIFT = 7;
  localparam logic [19:0] PERIPH_COUNT       = 20'h00007;
  localparam logic [19:0] MID_COUNT          = 20'h00004;
  localparam logic [7:0]  COPRO_INT_TYPE     = 8'h10;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_T1   = 6'h02,
    ST_T2   = 6'h04,
    ST_T3   = 6'h08,
    ST_T4   = 6'h10,
    ST_HOLD = 6'h20
  } bus_state_t;

  typedef struct packed {
    logic        valid;
    logic [19:0] addr;
    logic        is_io;
    logic        is_write;
    logic        lock;
    logic        numerics;
  } bus_req_t;

  typedef struct packed {
    logic [19:0] upper_start;
    logic [19:0] upper_end;
    logic        upper_io;
    logic        upper_ign;
    logic        lower_en;
    logic [19:0] lower_end;
    logic        lower_ign;
    logic        mid_en;
    logic [19:0] mid_base;
    logic [3:0]  mid_shift;
    logic        mid_ign;
    logic        periph_en;
    logic [19:0] periph_base;
    logic        periph_io;
    logic        periph_addr_mode;
    logic        periph_ign;
    logic        numerics_mode;
  } cs_cfg_t;

  localparam cs_cfg_t CS_CFG_RESET = '{
    upper_start:      UPPER_RESET_START,
    upper_end:        UPPER_RESET_END,
    upper_io:         1'b0,
    upper_ign:        1'b0,
    lower_en:         1'b0,
    lower_end:        ADDR_ZERO,
    lower_ign:        1'b0,
    mid_en:           1'b0,
    mid_base:         ADDR_ZERO,
    mid_shift:        MID_SHIFT_RESET,
    mid_ign:          1'b0,
    periph_en:        1'b0,
    periph_base:      ADDR_ZERO,
    periph_io:        1'b0,
    periph_addr_mode: 1'b0,
    periph_ign:       1'b0,
    numerics_mode:    1'b0
  };

endpackage

// ===== local_bus_ctrl.sv
// local bus control: strobes, ready, transceivers, lock, hold and chip selects
// assumes the core presents one request at a time and holds it until taken
//
// Function
// - write strobe marks data to be stored
// - queue mode: write pin carries queue status high
// - cycle ends on ready unless ready ignored
// - async ready synchronised on rise, direct on fall
// - transceiver enable only during data transfer
// - direction output follows transfer direction
// - no hold grant while lock is active
// - hold granted only at unlocked instruction boundary
// - bus and control float while hold acknowledged
// - upper select for cycles in its range
// - upper select defaults to top memory kilobyte
// - upper/lower strapped low in reset: float mode
// - lower select off after reset, memory only
// - four mid selects for memory in block
// - numerics mode turns mid pins into handshake
// - error at numerics start raises type 16
// - coprocessor select on coprocessor access
// - seven peripheral selects, top two address option
`timescale 1ns/10ps

module local_bus_ctrl
  import lbc_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire bus_req_t   req_i,
  output logic            req_ack_o,
  output logic            bus_done_o,
  input  wire logic       inst_boundary_i,
  input  wire logic       lock_prefix_i,
  input  wire logic [1:0] queue_status_i,
  input  wire logic       queue_mode_strap_n_i,
  input  wire logic       powerdown_i,
  input  wire cs_cfg_t    cs_cfg_i,
  input  wire logic       cs_cfg_load_i,
  input  wire logic       numerics_op_start_i,
  output logic            copro_request_o,
  output logic            copro_int_o,
  output logic [7:0]      copro_int_type_o,
  output logic            clock_output_o,
  input  wire logic       async_ready_in_i,
  input  wire logic       sync_ready_in_i,
  output logic            ale_queue_status_lo_o,
  output logic            write_queue_status_hi_n_o,
  output logic            xcvr_enable_n_o,
  output logic            xcvr_direction_o,
  output logic            ctl_oe_o,
  output logic            bus_oe_o,
  output logic            lock_n_o,
  output logic            lock_oe_o,
  input  wire logic       hold_req_i,
  output logic            bus_grant_ack_o,
  input  wire logic       upper_select_i,
  input  wire logic       lower_select_i,
  output logic            upper_select_n_o,
  output logic            lower_select_n_o,
  output logic            select_oe_o,
  input  wire logic [3:0] midrange_select_i,
  output logic [3:0]      midrange_select_n_o,
  output logic [3:0]      midrange_select_oe_o,
  output logic [4:0]      periph_select_low_five_n_o,
  output logic            periph_select_5_or_addr1_o,
  output logic            periph_select_6_or_addr2_o,
  output logic            emulation_float_mode_o
);

  bus_state_t  state;
  bus_state_t  next_state;
  bus_req_t    cur_req;
  cs_cfg_t     cfg;
  logic        phase;
  logic        ard_sync1;
  logic        ard_sync2;
  logic        ard_rise;
  logic        strap_done;
  logic        float_mode;
  logic        queue_mode;
  logic        in_cycle;
  logic        lock_active;
  logic        grant_hold;
  logic        take_req;
  logic        cycle_ready;
  logic        sel_ignore;
  logic        hit_upper;
  logic        hit_lower;
  logic        hit_mid;
  logic        hit_periph;
  logic [19:0] mid_off;
  logic [19:0] mid_blk;
  logic [19:0] per_off;
  logic [19:0] per_blk;
  logic [3:0]  mid_dec;
  logic [6:0]  per_dec;
  logic        cs_force_off;

  assign in_cycle    = (state == ST_T1) || (state == ST_T2) ||
                       (state == ST_T3) || (state == ST_T4);
  // a locked cycle or a lock prefix sequence keeps other masters out
  assign lock_active = (in_cycle && cur_req.lock) || lock_prefix_i;
  assign grant_hold  = (state == ST_IDLE) && phase && hold_req_i &&
                       inst_boundary_i && !lock_active && !powerdown_i;
  // a pending hold outranks a new core request
  assign take_req    = (state == ST_IDLE) && phase && req_i.valid &&
                       !grant_hold && !powerdown_i && strap_done && !float_mode;

  // address decode of the latched request
  always_comb begin
    mid_off    = cur_req.addr - cfg.mid_base;
    mid_blk    = mid_off >> cfg.mid_shift;
    per_off    = cur_req.addr - cfg.periph_base;
    per_blk    = per_off >> PERIPH_BLOCK_SHIFT;
    hit_upper  = (cur_req.addr >= cfg.upper_start) &&
                 (cur_req.addr <= cfg.upper_end) &&
                 (!cur_req.is_io || cfg.upper_io);
    hit_lower  = cfg.lower_en && !cur_req.is_io &&
                 (cur_req.addr <= cfg.lower_end);
    hit_mid    = cfg.mid_en && !cfg.numerics_mode && !cur_req.is_io &&
                 (cur_req.addr >= cfg.mid_base) && (mid_blk < MID_COUNT);
    hit_periph = cfg.periph_en && (cur_req.is_io == cfg.periph_io) &&
                 (cur_req.addr >= cfg.periph_base) && (per_blk < PERIPH_COUNT);
    mid_dec    = 4'h0;
    per_dec    = 7'h00;
    if (hit_mid) begin
      mid_dec[mid_blk[1:0]] = 1'b1;
    end
    if (hit_periph) begin
      per_dec[per_blk[2:0]] = 1'b1;
    end
    if (cfg.periph_addr_mode) begin
      per_dec[6:5] = 2'h0;
    end
    // a hit in a group set to ignore ready ends the wait by itself
    sel_ignore = (hit_upper && cfg.upper_ign) || (hit_lower && cfg.lower_ign) ||
                 (hit_mid && cfg.mid_ign) || (hit_periph && cfg.periph_ign);
  end

  // async path resolved at rise, both readies qualified at fall
  // sync ready goes straight in, so the far side owns its setup
  assign cycle_ready = sel_ignore || sync_ready_in_i ||
                       (ard_rise && async_ready_in_i);

  // sequencer: each state lasts one processor clock unless waiting
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (grant_hold) begin
          next_state = ST_HOLD;
        end else if (take_req) begin
          next_state = ST_T1;
        end
      end
      ST_T1: if (phase) next_state = ST_T2;
      ST_T2: if (phase) next_state = ST_T3;
      ST_T3: if (phase && cycle_ready) next_state = ST_T4;
      ST_T4: if (phase) next_state = ST_IDLE;
      ST_HOLD: if (phase && !hold_req_i) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // processor clock output at half the system rate
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= 1'b0;
    end else begin
      phase <= !phase;
    end
  end
  assign clock_output_o = phase;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request latched at take; decode and strobes read only this copy
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_req <= '0;
    end else if (take_req) begin
      cur_req <= req_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg <= CS_CFG_RESET;
    end else if (cs_cfg_load_i) begin
      // loading mid-cycle changes the selects on the next edge
      cfg <= cs_cfg_i;
    end
  end

  // two flops tame the pin; the rise copy is held over to the fall edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ard_sync1 <= 1'b0;
      ard_sync2 <= 1'b0;
      ard_rise  <= 1'b0;
    end else begin
      ard_sync1 <= async_ready_in_i;
      ard_sync2 <= ard_sync1;
      if (!phase) begin
        ard_rise <= ard_sync2;
      end
    end
  end

  // straps are caught on the first edge after reset release
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done <= 1'b0;
      float_mode <= 1'b0;
      queue_mode <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      float_mode <= !upper_select_i && !lower_select_i;
      queue_mode <= !queue_mode_strap_n_i;
    end
  end
  assign emulation_float_mode_o = float_mode;

  // one-cycle handshake pulses back to the core
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_ack_o  <= 1'b0;
      bus_done_o <= 1'b0;
    end else begin
      req_ack_o  <= take_req;
      bus_done_o <= (state == ST_T4) && phase;
    end
  end

  // strobes and transceiver control
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ale_queue_status_lo_o     <= 1'b0;
      write_queue_status_hi_n_o <= 1'b1;
      xcvr_enable_n_o           <= 1'b1;
      xcvr_direction_o          <= 1'b0;
      lock_n_o                  <= 1'b1;
    end else begin
      // queue mode: pins mirror the core queue status every edge
      if (queue_mode) begin
        ale_queue_status_lo_o     <= queue_status_i[0];
        write_queue_status_hi_n_o <= queue_status_i[1];
      end else begin
        ale_queue_status_lo_o     <= (state == ST_T1);
        write_queue_status_hi_n_o <= !(cur_req.is_write &&
                                       ((state == ST_T2) || (state == ST_T3)));
      end
      xcvr_enable_n_o  <= !((state == ST_T2) || (state == ST_T3) ||
                            ((state == ST_T4) && cur_req.is_write));
      if (in_cycle) begin
        xcvr_direction_o <= cur_req.is_write;
      end
      lock_n_o <= !lock_active;
    end
  end

  // output enables: floated in reset and in float mode; all but select_oe_o also float in hold
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_oe_o    <= 1'b0;
      bus_oe_o    <= 1'b0;
      lock_oe_o   <= 1'b0;
      select_oe_o <= 1'b0;
    end else begin
      ctl_oe_o    <= strap_done && !float_mode && (next_state != ST_HOLD);
      bus_oe_o    <= strap_done && !float_mode && (next_state != ST_HOLD);
      lock_oe_o   <= strap_done && !float_mode && (next_state != ST_HOLD);
      select_oe_o <= strap_done && !float_mode;
    end
  end

  // grant tracks the sequencer and drops on the next edge in powerdown
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_grant_ack_o <= 1'b0;
    end else begin
      bus_grant_ack_o <= (next_state == ST_HOLD) && !powerdown_i;
    end
  end

  // chip selects, active low
  // decode reads the latched request, so selects lag the state by one edge
  assign cs_force_off = !in_cycle || powerdown_i || (state == ST_HOLD);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_select_n_o           <= 1'b1;
      lower_select_n_o           <= 1'b1;
      midrange_select_n_o        <= 4'hF;
      periph_select_low_five_n_o <= 5'h1F;
      periph_select_5_or_addr1_o <= 1'b1;
      periph_select_6_or_addr2_o <= 1'b1;
    end else begin
      upper_select_n_o           <= cs_force_off || !hit_upper;
      lower_select_n_o           <= cs_force_off || !hit_lower;
      periph_select_low_five_n_o <= cs_force_off ? 5'h1F : ~per_dec[4:0];
      if (cfg.periph_addr_mode) begin
        periph_select_5_or_addr1_o <= cur_req.addr[1];
        periph_select_6_or_addr2_o <= cur_req.addr[2];
      end else begin
        periph_select_5_or_addr1_o <= cs_force_off || !per_dec[5];
        periph_select_6_or_addr2_o <= cs_force_off || !per_dec[6];
      end
      if (cfg.numerics_mode) begin
        midrange_select_n_o <= {!(!cs_force_off && cur_req.numerics), 3'h7};
      end else begin
        midrange_select_n_o <= cs_force_off ? 4'hF : ~mid_dec;
      end
    end
  end

  // pins 0 and 1 turn into inputs in numerics mode
  assign midrange_select_oe_o = {select_oe_o, select_oe_o,
                                 select_oe_o && !cfg.numerics_mode,
                                 select_oe_o && !cfg.numerics_mode};
  assign copro_request_o      = cfg.numerics_mode && midrange_select_i[0];

  // error pin is active low; the interrupt type is fixed
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      copro_int_o      <= 1'b0;
      copro_int_type_o <= 8'h00;
    end else begin
      copro_int_o      <= numerics_op_start_i && cfg.numerics_mode &&
                          !midrange_select_i[1];
      copro_int_type_o <= COPRO_INT_TYPE;
    end
  end

endmodule // local_bus_ctrl

// ===== local_bus_ctrl_properties.sv
// assertions on the local bus control block ports
// assumes the mode straps only change while reset is held
`timescale 1ns/10ps
module local_bus_ctrl_checker
  import lbc_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  input wire logic       req_ack_o,
  input wire logic       bus_done_o,
  input wire logic       inst_boundary_i,
  input wire logic       lock_prefix_i,
  input wire logic       queue_mode_strap_n_i,
  input wire logic       powerdown_i,
  input wire logic       numerics_op_start_i,
  input wire logic       copro_int_o,
  input wire logic [7:0] copro_int_type_o,
  input wire logic       write_queue_status_hi_n_o,
  input wire logic       xcvr_enable_n_o,
  input wire logic       xcvr_direction_o,
  input wire logic       ctl_oe_o,
  input wire logic       bus_oe_o,
  input wire logic       lock_n_o,
  input wire logic       lock_oe_o,
  input wire logic       hold_req_i,
  input wire logic       bus_grant_ack_o,
  input wire logic       upper_select_n_o,
  input wire logic       lower_select_n_o,
  input wire logic [3:0] midrange_select_i,
  input wire logic [4:0] periph_select_low_five_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence s_no_done;
    !bus_done_o [*6];
  endsequence
  sequence s_grant_rise;
    $rose(bus_grant_ack_o);
  endsequence

  cycle_len_a: assert property (req_ack_o |=> s_no_done)
    else $error("bus cycle ended too early");
  den_start_a: assert property (req_ack_o |-> ##[1:6] !xcvr_enable_n_o)
    else $error("transceiver enable missing in cycle");
  den_stop_a: assert property (bus_done_o |-> ##2 xcvr_enable_n_o)
    else $error("transceiver enable after cycle end");
  strobe_wr_a: assert property (queue_mode_strap_n_i && !write_queue_status_hi_n_o
      |-> !xcvr_enable_n_o && xcvr_direction_o)
    else $error("write strobe outside a write transfer");
  hold_float_a: assert property (bus_grant_ack_o && $past(hold_req_i)
      |-> !bus_oe_o && !ctl_oe_o)
    else $error("bus driven while granted");
  hold_sel_a: assert property (bus_grant_ack_o
      |-> upper_select_n_o && lower_select_n_o && (&periph_select_low_five_n_o))
    else $error("select active while granted");
  hold_keep_a: assert property (bus_grant_ack_o && hold_req_i && !powerdown_i
      |=> bus_grant_ack_o)
    else $error("grant dropped while still requested");
  grant_cond_a: assert property (s_grant_rise
      |-> $past(lock_n_o) && ($past(hold_req_i && inst_boundary_i && !lock_prefix_i)
      || $past(hold_req_i && inst_boundary_i && !lock_prefix_i, 2)))
    else $error("grant outside an unlocked boundary");
  lock_grant_a: assert property (!lock_n_o && lock_oe_o |-> !bus_grant_ack_o)
    else $error("grant during locked cycle");
  copro_int_a: assert property (copro_int_o |-> $past(numerics_op_start_i)
      && !$past(midrange_select_i[1]) && copro_int_type_o == COPRO_INT_TYPE)
    else $error("coprocessor interrupt without cause");
  pd_quiet_a: assert property (powerdown_i && $past(powerdown_i) && $past(powerdown_i, 2)
      |-> upper_select_n_o && !bus_grant_ack_o)
    else $error("select or grant active in powerdown");
endmodule // local_bus_ctrl_checker

bind local_bus_ctrl local_bus_ctrl_checker i_chk (.*);

// ===== far_side.sv
// far side model: ready source of memory and io, external bus master
// assumes an active low transceiver enable from the block
`timescale 1ns/10ps
module far_side (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       xcvr_enable_n_i,
  input  wire logic [3:0] wait_i,
  input  wire logic       use_async_i,
  input  wire logic       want_bus_i,
  output logic            sync_ready_o,
  output logic            async_ready_o,
  output logic            hold_req_o
);
  logic [3:0] cnt;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 4'h0;
    end else begin
      cnt <= xcvr_enable_n_i ? 4'h0 : cnt + ((cnt != 4'hF) ? 4'h1 : 4'h0);
    end
  end
  // ready launched on the edge, so it meets setup
  assign sync_ready_o  = !use_async_i && !xcvr_enable_n_i && cnt >= wait_i;
  assign async_ready_o = use_async_i && !xcvr_enable_n_i && cnt >= wait_i;
  // request held for as long as the bus is wanted
  assign hold_req_o = want_bus_i;
endmodule // far_side

// ===== tb.sv
// self-checking bench for the local bus control block
// assumes the far side model and the port checker bound by name
`timescale 1ns/10ps
module tb;
  import lbc_pkg::*;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, ld_p = 1'b0, ib = 1'b1, lp = 1'b0, qm_n = 1'b1;
  logic pd = 1'b0, nst = 1'b0, us = 1'b1, ls = 1'b1, asy = 1'b0, want = 1'b0;
  logic [1:0] qs = 2'h0;
  logic [3:0] mid_in = 4'hF, wt = 4'h0, mcs, moe;
  bus_req_t   req = '0;
  cs_cfg_t    cfg = CS_CFG_RESET, nc = CS_CFG_RESET;
  logic ack, done, den_n, wr_n, ale, dir, hack, upper_select, lower_select, cint, creq, flt, soe;
  logic oe_b, oe_c, oe_l, p5, p6, sync_ready_in, async_ready_in, hreq, cko;
  logic [4:0] pcs;
  logic [7:0] ctype;
  int bad_count = 0, n_checks = 0;

  local_bus_ctrl i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req), .req_ack_o(ack),
    .bus_done_o(done), .inst_boundary_i(ib), .lock_prefix_i(lp), .queue_status_i(qs),
    .queue_mode_strap_n_i(qm_n), .powerdown_i(pd), .cs_cfg_i(cfg), .cs_cfg_load_i(ld_p),
    .numerics_op_start_i(nst), .copro_request_o(creq), .copro_int_o(cint),
    .copro_int_type_o(ctype), .clock_output_o(cko), .async_ready_in_i(async_ready_in),
    .sync_ready_in_i(sync_ready_in), .ale_queue_status_lo_o(ale), .write_queue_status_hi_n_o(wr_n),
    .xcvr_enable_n_o(den_n), .xcvr_direction_o(dir), .ctl_oe_o(oe_c), .bus_oe_o(oe_b),
    .lock_n_o(), .lock_oe_o(oe_l), .hold_req_i(hreq), .bus_grant_ack_o(hack),
    .upper_select_i(us), .lower_select_i(ls), .upper_select_n_o(upper_select),
    .lower_select_n_o(lower_select), .select_oe_o(soe), .midrange_select_i(mid_in),
    .midrange_select_n_o(mcs), .midrange_select_oe_o(moe), .periph_select_low_five_n_o(pcs),
    .periph_select_5_or_addr1_o(p5), .periph_select_6_or_addr2_o(p6),
    .emulation_float_mode_o(flt));
  far_side i_far (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .xcvr_enable_n_i(den_n),
    .wait_i(wt), .use_async_i(asy), .want_bus_i(want), .sync_ready_o(sync_ready_in),
    .async_ready_o(async_ready_in), .hold_req_o(hreq));

  always #20 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask
  task automatic ld();
    @(posedge clk_sys_i);
    cfg <= nc;
    ld_p <= 1'b1;
    @(posedge clk_sys_i) ld_p <= 1'b0;
  endtask
  task automatic do_reset(input logic q, u, l);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    qm_n <= q;
    us <= u;
    ls <= l;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(negedge clk_sys_i);
  endtask
  // one bus cycle; sel collects selects and strobe seen low
  task automatic cyc(input bus_req_t r, output logic [13:0] sel, output int gap);
    int n;
    sel = '0;
    @(posedge clk_sys_i) req <= r;
    wait_for(ack, 40, n);
    chk(cko, 1'b0);
    @(posedge clk_sys_i) req.valid <= 1'b0;
    gap = 0;
    while (done !== 1'b1 && gap < 200) begin
      @(negedge clk_sys_i);
      gap++;
      sel |= ~{upper_select, lower_select, mcs, pcs, p6, p5, wr_n};
      if (den_n === 1'b0) chk(dir, r.is_write);
    end
    chk(n + gap < 240, 1);
  endtask
  // request already raised: wait for it to complete
  task automatic finish_req();
    int n;
    wait_for(ack, 30, n);
    @(posedge clk_sys_i) req.valid <= 1'b0;
    wait_for(done, 60, n);
    chk(n < 60, 1);
  endtask

  task automatic t_tables();
    logic [19:0] a [12] = '{20'hFFC00, 20'hFFC00, 20'hFFFFF, 20'h00100, 20'h00100, 20'h00100,
      20'h80800, 20'h80800, 20'h01180, 20'h01300, 20'h01180, 20'hFFBFF};
    logic [11:0] io = 12'h3A2;
    logic [13:0] e [12] = '{14'h2000, 14'h0, 14'h2001, 14'h0, 14'h1000, 14'h0,
      14'h0400, 14'h0, 14'h0040, 14'h0004, 14'h0, 14'h0};
    logic [13:0] s;
    int g;
    for (int i = 0; i < 12; i++) begin
      if (i == 4) begin
        nc = '{upper_start: UPPER_RESET_START, upper_end: UPPER_RESET_END, lower_en: 1'b1,
          lower_end: 20'h003FF, mid_en: 1'b1, mid_base: 20'h80000, mid_shift: 4'hA,
          periph_en: 1'b1, periph_base: 20'h01000, periph_io: 1'b1, default: '0};
        ld();
      end
      cyc('{1'b1, a[i], io[i], i == 2, i == 2, 1'b0}, s, g);
      chk(s, e[i]);
    end
    nc.periph_addr_mode = 1'b1;
    ld();
    cyc('{1'b1, 20'h00104, 1'b0, 1'b0, 1'b0, 1'b0}, s, g);
    chk({p6, p5}, 2'b10);
  endtask
  task automatic t_ready();
    logic [13:0] s;
    int g0, g;
    bus_req_t r = '{1'b1, 20'hFFC00, 1'b0, 1'b0, 1'b0, 1'b0};
    cyc(r, s, g0);
    @(posedge clk_sys_i) wt <= 4'h6;
    cyc(r, s, g);
    chk(g > g0, 1);
    @(posedge clk_sys_i) asy <= 1'b1;
    cyc(r, s, g);
    chk(g > g0, 1);
    nc.upper_ign = 1'b1;
    ld();
    cyc(r, s, g);
    chk(g, g0);
    nc.upper_ign = 1'b0;
    ld();
    wt <= 4'h0;
    asy <= 1'b0;
  endtask
  task automatic t_numerics();
    logic [13:0] s;
    int n;
    nc.periph_addr_mode = 1'b0;
    nc.numerics_mode = 1'b1;
    ld();
    mid_in <= 4'hD;
    @(negedge clk_sys_i);
    chk({creq, moe[1:0]}, 3'b100);
    @(posedge clk_sys_i) nst <= 1'b1;
    @(posedge clk_sys_i) nst <= 1'b0;
    wait_for(cint, 3, n);
    chk({n < 3, ctype}, 9'h110);
    @(posedge clk_sys_i) mid_in <= 4'hE;
    @(posedge clk_sys_i) nst <= 1'b1;
    @(posedge clk_sys_i) nst <= 1'b0;
    wait_for(cint, 4, n);
    chk({creq, n == 4}, 2'b01);
    cyc('{1'b1, 20'h000F8, 1'b1, 1'b0, 1'b0, 1'b1}, s, n);
    chk(s & 14'h3CFF, 14'h0800);
    nc.numerics_mode = 1'b0;
    ld();
    mid_in <= 4'hF;
  endtask
  task automatic t_hold_power();
    int n;
    @(posedge clk_sys_i);
    lp <= 1'b1;
    want <= 1'b1;
    repeat (12) @(negedge clk_sys_i);
    chk(hack, 0);
    @(posedge clk_sys_i);
    lp <= 1'b0;
    ib <= 1'b0;
    repeat (12) @(negedge clk_sys_i);
    chk(hack, 0);
    @(posedge clk_sys_i) ib <= 1'b1;
    wait_for(hack, 8, n);
    chk({hack, oe_b, oe_c, upper_select, lower_select, pcs}, 10'h27F);
    @(posedge clk_sys_i) req <= '{1'b1, 20'hFFC00, 1'b0, 1'b0, 1'b0, 1'b0};
    wait_for(ack, 10, n);
    chk({n == 10, hack}, 2'b11);
    @(posedge clk_sys_i) want <= 1'b0;
    finish_req();
    chk(hack, 0);
    @(posedge clk_sys_i) pd <= 1'b1;
    @(posedge clk_sys_i) req <= '{1'b1, 20'hFFC00, 1'b0, 1'b0, 1'b0, 1'b0};
    wait_for(ack, 10, n);
    chk({n == 10, hack, upper_select}, 3'b101);
    @(posedge clk_sys_i) pd <= 1'b0;
    finish_req();
  endtask
  task automatic t_straps();
    do_reset(1'b0, 1'b1, 1'b1);
    for (int v = 0; v < 4; v++) begin
      @(posedge clk_sys_i) qs <= 2'(v);
      repeat (2) @(negedge clk_sys_i);
      chk({wr_n, ale}, v);
    end
    do_reset(1'b1, 1'b0, 1'b0);
    chk({flt, oe_b, oe_c, soe}, 4'h8);
    do_reset(1'b1, 1'b1, 1'b1);
    chk({flt, oe_b}, 2'b01);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge clk_sys_i);
    chk({oe_b, oe_c, oe_l, hack, upper_select, lower_select, den_n, wr_n, pcs, mcs}, 17'h01FFF);
    chk(cko, 1'b0);
    @(posedge clk_sys_i) rstn_i <= 1'b1;
    repeat (4) @(negedge clk_sys_i);
    t_ready();
    t_tables();
    t_numerics();
    t_hold_power();
    t_straps();
    test_done();
  end
endmodule // tb
